/* hdl/bwa_params.svh */
`ifndef BWA_PARAMS_SVH
`define BWA_PARAMS_SVH

`define BWA_ADDR_W       8
`define BWA_OFF_CTRL     8'h00
`define BWA_OFF_DEST     8'h04
`define BWA_OFF_SRC      8'h08
`define BWA_OFF_IMM      8'h0C
`define BWA_OFF_PAIR_HI  8'h10
`define BWA_OFF_FLAGS    8'h14
`define BWA_OFF_STATUS   8'h18

`define BWA_FLAG_C       0
`define BWA_FLAG_Z       1
`define BWA_FLAG_N       2
`define BWA_FLAG_V       3
`define BWA_FLAG_S       4
`define BWA_FLAG_H       5

`define BWA_STAT_BUSY    0
`define BWA_STAT_CYC_LSB 4
`define BWA_STAT_CYC_MSB 7

`define BWA_OP_LAST      4'hB
`define BWA_BYTE_ZERO    8'h00
`define BWA_WORD_ZERO    32'h00000000
`define BWA_CYC_STEP     4'h1
`define BWA_CYC_NONE     4'h0
`define BWA_RESP_OKAY    2'h0
`define BWA_RESP_SLVERR  2'h2

`endif

/* hdl/bwa_pkg.sv */
`default_nettype none
`include "bwa_params.svh"

package bwa_pkg;

	typedef enum logic [3:0] {
		add_op,
		add_with_carry_op,
		subtract_op,
		subtract_with_borrow_op,
		subtract_immediate_op,
		subtract_immediate_with_borrow_op,
		word_add_immediate_op,
		word_subtract_immediate_op,
		and_op,
		and_immediate_op,
		or_op,
		or_immediate_op
	} bwa_op_t;

	typedef enum logic {
		ST_IDLE,
		ST_WORD_HIGH
	} bwa_state_t;

	typedef struct packed {
		logic                   awHeld;
		logic [`BWA_ADDR_W-1:0] awAddr;
		logic                   wHeld;
		logic [31:0]            wData;
		logic [3:0]             wStrb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [1:0]             rresp;
		logic [31:0]            rdata;
		logic [7:0]             dest;
		logic [7:0]             src;
		logic [7:0]             imm;
		logic [7:0]             pairHi;
		logic [7:0]             flags;
		bwa_op_t                op;
		logic                   pending;
		bwa_state_t             state;
		logic                   lowCarry;
		logic                   lowZero;
		logic [3:0]             cycles;
	} bwa_regs_t;

endpackage

`default_nettype wire

/* hdl/bwa_add_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface bwa_add_if;
	logic [7:0] a;
	logic [7:0] b;
	logic       sub;
	logic       carryIn;
	logic [7:0] result;
	logic       carryOut;
	logic       halfOut;
	logic       ovfOut;

	modport user (
		output a,
		output b,
		output sub,
		output carryIn,
		input  result,
		input  carryOut,
		input  halfOut,
		input  ovfOut
	);

	modport core (
		input  a,
		input  b,
		input  sub,
		input  carryIn,
		output result,
		output carryOut,
		output halfOut,
		output ovfOut
	);
endinterface

`default_nettype wire

/* hdl/bwa_byte_adder.sv */
`timescale 1ns/1ps
`default_nettype none

module bwa_byte_adder (
	bwa_add_if.core addBus
);
	// Subtraction runs as a + ~b + ~borrow, so one adder serves both directions.
	logic [7:0] bEff;
	logic       cinEff;
	logic [8:0] sum9;
	logic [4:0] sum5;

	assign bEff   = addBus.sub ? ~addBus.b : addBus.b;
	assign cinEff = addBus.sub ? ~addBus.carryIn : addBus.carryIn;
	assign sum9   = {1'b0, addBus.a} + {1'b0, bEff} + {8'h00, cinEff};
	assign sum5   = {1'b0, addBus.a[3:0]} + {1'b0, bEff[3:0]} + {4'h0, cinEff};

	assign addBus.result   = sum9[7:0];
	// A carry out of a subtraction means no borrow, hence the inversion.
	assign addBus.carryOut = sum9[8] ^ addBus.sub;
	assign addBus.halfOut  = sum5[4] ^ addBus.sub;
	assign addBus.ovfOut   = (addBus.a[7] == bEff[7]) && (sum9[7] != addBus.a[7]);
endmodule

`default_nettype wire

/* hdl/bwa_alu.sv */
// Notes on behaviour
// - Byte add, optional carry, flags ZCNVH, 1 cycle.
// - Register subtract, optional borrow, flags ZCNVH, 1 cycle.
// - Subtract immediate from register, flags ZCNVH, 1 cycle.
// - Subtract immediate and carry, flags ZCNVH, 1 cycle.
// - Word pair plus immediate, flags ZCNVS, 2 cycles.
// - Word pair minus immediate, flags ZCNVS, 2 cycles.
// - AND with register or immediate, flags ZNV, 1 cycle.
// - OR with register or immediate, flags ZNV, 1 cycle.
`timescale 1ns/1ps
`default_nettype none
`include "bwa_params.svh"

module bwa_alu (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   clkEn,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [`BWA_ADDR_W-1:0] awaddr,
	input  wire logic                   wvalid,
	output logic                        wready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	output logic                        bvalid,
	input  wire logic                   bready,
	output logic [1:0]                  bresp,
	input  wire logic                   arvalid,
	output logic                        arready,
	input  wire logic [`BWA_ADDR_W-1:0] araddr,
	output logic                        rvalid,
	input  wire logic                   rready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        busy,
	output bwa_pkg::bwa_op_t            lastOp,
	output logic [7:0]                  flagsOut
);
	import bwa_pkg::*;

	bwa_regs_t q;
	bwa_regs_t d;

	bwa_add_if addBus ();

	bwa_byte_adder adder (
		.addBus (addBus)
	);

	logic                   awFire;
	logic                   wFire;
	logic                   doWrite;
	logic [`BWA_ADDR_W-1:0] wrAddr;
	logic [31:0]            wrData;
	logic [3:0]             wrStrb;
	logic                   arFire;
	logic                   useImm;
	logic                   useCarry;
	logic                   isSub;
	logic [7:0]             opB;
	logic [7:0]             res;
	logic                   resZero;
	logic [7:0]             logicRes;

	assign busy     = q.pending || (q.state != ST_IDLE);
	assign lastOp   = q.op;
	assign flagsOut = q.flags;
	assign bvalid   = q.bvalid;
	assign bresp    = q.bresp;
	assign rvalid   = q.rvalid;
	assign rdata    = q.rdata;
	assign rresp    = q.rresp;

	// Address and data are taken independently, so the master may offer them in either order.
	assign awready = clkEn && !q.awHeld && !q.bvalid;
	assign wready  = clkEn && !q.wHeld && !q.bvalid;
	assign awFire  = awvalid && awready;
	assign wFire   = wvalid && wready;
	assign doWrite = (q.awHeld || awFire) && (q.wHeld || wFire);
	assign wrAddr  = q.awHeld ? q.awAddr : awaddr;
	assign wrData  = q.wHeld ? q.wData : wdata;
	assign wrStrb  = q.wHeld ? q.wStrb : wstrb;
	assign arready = clkEn && !q.rvalid;
	assign arFire  = arvalid && arready;

	always_comb begin
		useImm = 1'b0;
		useCarry = 1'b0;
		isSub = 1'b0;
		case (q.op)
			add_with_carry_op: begin
				useCarry = 1'b1;
			end
			subtract_op: begin
				isSub = 1'b1;
			end
			subtract_with_borrow_op: begin
				isSub = 1'b1;
				useCarry = 1'b1;
			end
			subtract_immediate_op: begin
				isSub = 1'b1;
				useImm = 1'b1;
			end
			subtract_immediate_with_borrow_op: begin
				isSub = 1'b1;
				useImm = 1'b1;
				useCarry = 1'b1;
			end
			word_add_immediate_op: begin
				useImm = 1'b1;
			end
			word_subtract_immediate_op: begin
				isSub = 1'b1;
				useImm = 1'b1;
			end
			and_immediate_op,
			or_immediate_op: begin
				useImm = 1'b1;
			end
			default: begin
				useImm = 1'b0;
			end
		endcase
	end

	assign opB = useImm ? q.imm : q.src;

	// The second word step reuses the byte adder on the high byte with the kept carry.
	always_comb begin
		if (q.state == ST_WORD_HIGH) begin
			addBus.a = q.pairHi;
			addBus.b = `BWA_BYTE_ZERO;
			addBus.carryIn = q.lowCarry;
		end else begin
			addBus.a = q.dest;
			addBus.b = opB;
			addBus.carryIn = useCarry && q.flags[`BWA_FLAG_C];
		end
		addBus.sub = isSub;
	end

	assign res      = addBus.result;
	assign resZero  = (res == `BWA_BYTE_ZERO);
	assign logicRes = (q.op == and_op || q.op == and_immediate_op) ? (q.dest & opB) : (q.dest | opB);

	function automatic logic [31:0] readMux(input bwa_regs_t r, input logic [`BWA_ADDR_W-1:0] addr);
		logic [31:0] v;
		v = `BWA_WORD_ZERO;
		case (addr)
			`BWA_OFF_CTRL: begin
				v[3:0] = r.op;
			end
			`BWA_OFF_DEST: begin
				v[7:0] = r.dest;
			end
			`BWA_OFF_SRC: begin
				v[7:0] = r.src;
			end
			`BWA_OFF_IMM: begin
				v[7:0] = r.imm;
			end
			`BWA_OFF_PAIR_HI: begin
				v[7:0] = r.pairHi;
			end
			`BWA_OFF_FLAGS: begin
				v[7:0] = r.flags;
			end
			`BWA_OFF_STATUS: begin
				v[`BWA_STAT_BUSY] = r.pending || (r.state != ST_IDLE);
				v[`BWA_STAT_CYC_MSB:`BWA_STAT_CYC_LSB] = r.cycles;
			end
			default: begin
				v = `BWA_WORD_ZERO;
			end
		endcase
		return v;
	endfunction

	function automatic logic addrKnown(input logic [`BWA_ADDR_W-1:0] addr);
		return addr == `BWA_OFF_CTRL || addr == `BWA_OFF_DEST || addr == `BWA_OFF_SRC
			|| addr == `BWA_OFF_IMM || addr == `BWA_OFF_PAIR_HI || addr == `BWA_OFF_FLAGS
			|| addr == `BWA_OFF_STATUS;
	endfunction

	always_comb begin
		d = q;

		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (doWrite) begin
			d.awHeld = 1'b0;
			d.wHeld = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = addrKnown(wrAddr) ? `BWA_RESP_OKAY : `BWA_RESP_SLVERR;
			// Operands stay frozen while an operation runs; such writes are answered but dropped.
			if (wrStrb[0] && !busy) begin
				case (wrAddr)
					`BWA_OFF_CTRL: begin
						if (wrData[3:0] <= `BWA_OP_LAST) begin
							d.op = bwa_op_t'(wrData[3:0]);
							d.pending = 1'b1;
							d.cycles = `BWA_CYC_NONE;
						end
					end
					`BWA_OFF_DEST: begin
						d.dest = wrData[7:0];
					end
					`BWA_OFF_SRC: begin
						d.src = wrData[7:0];
					end
					`BWA_OFF_IMM: begin
						d.imm = wrData[7:0];
					end
					`BWA_OFF_PAIR_HI: begin
						d.pairHi = wrData[7:0];
					end
					`BWA_OFF_FLAGS: begin
						d.flags = wrData[7:0];
					end
					default: begin
						d.flags = q.flags;
					end
				endcase
			end
		end else begin
			if (awFire) begin
				d.awHeld = 1'b1;
				d.awAddr = awaddr;
			end
			if (wFire) begin
				d.wHeld = 1'b1;
				d.wData = wdata;
				d.wStrb = wstrb;
			end
		end

		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end
		if (arFire) begin
			d.rvalid = 1'b1;
			d.rdata = readMux(q, araddr);
			d.rresp = addrKnown(araddr) ? `BWA_RESP_OKAY : `BWA_RESP_SLVERR;
		end

		case (q.state)
			ST_IDLE: begin
				if (q.pending) begin
					d.pending = 1'b0;
					d.cycles = q.cycles + `BWA_CYC_STEP;
					case (q.op)
						add_op,
						add_with_carry_op,
						subtract_op,
						subtract_with_borrow_op,
						subtract_immediate_op,
						subtract_immediate_with_borrow_op: begin
							d.dest = res;
							d.flags[`BWA_FLAG_C] = addBus.carryOut;
							d.flags[`BWA_FLAG_Z] = resZero;
							d.flags[`BWA_FLAG_N] = res[7];
							d.flags[`BWA_FLAG_V] = addBus.ovfOut;
							d.flags[`BWA_FLAG_H] = addBus.halfOut;
						end
						word_add_immediate_op,
						word_subtract_immediate_op: begin
							d.dest = res;
							d.lowCarry = addBus.carryOut;
							d.lowZero = resZero;
							d.state = ST_WORD_HIGH;
						end
						default: begin
							d.dest = logicRes;
							d.flags[`BWA_FLAG_Z] = (logicRes == `BWA_BYTE_ZERO);
							d.flags[`BWA_FLAG_N] = logicRes[7];
							d.flags[`BWA_FLAG_V] = 1'b0;
						end
					endcase
				end
			end
			ST_WORD_HIGH: begin
				d.pairHi = res;
				d.cycles = q.cycles + `BWA_CYC_STEP;
				d.flags[`BWA_FLAG_C] = addBus.carryOut;
				d.flags[`BWA_FLAG_Z] = q.lowZero && resZero;
				d.flags[`BWA_FLAG_N] = res[7];
				d.flags[`BWA_FLAG_V] = addBus.ovfOut;
				d.flags[`BWA_FLAG_S] = res[7] ^ addBus.ovfOut;
				d.state = ST_IDLE;
			end
			default: begin
				d.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else if (clkEn) begin
			q <= d;
		end
	end
endmodule

`default_nettype wire

/* verification/bwa_alu_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module bwa_alu_sva (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        clkEn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [7:0]  awaddr,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0]  wstrb,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arready,
	input wire logic        arvalid,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic        busy,
	input wire logic [7:0]  flagsOut
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence ctrlGo;
		awvalid && awready && wvalid && wready && awaddr == 8'h00 && wstrb[0] && !busy;
	endsequence
	a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("write answer missing");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer missing");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_write_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write taken during answer");
	a_enable_gate: assert property (!clkEn |-> !(awready || wready || arready))
		else $error("handshake while frozen");
	a_freeze_hold: assert property (!clkEn |=> $stable(flagsOut) && $stable(busy))
		else $error("state moved while frozen");
	a_byte_one_cycle: assert property (ctrlGo ##0 (wdata[3:0] < 4'hC && wdata[3:1] != 3'h3) ##1 clkEn |-> busy ##1 !busy)
		else $error("byte op length wrong");
	a_word_two_cycles: assert property (ctrlGo ##0 wdata[3:1] == 3'h3 ##1 clkEn[*2] |-> busy ##1 !busy)
		else $error("word op length wrong");
	a_logic_v_clear: assert property (ctrlGo ##0 wdata[3:2] == 2'h2 ##1 clkEn |=> !flagsOut[3])
		else $error("logic op left overflow set");
endmodule
bind bwa_alu bwa_alu_sva i_sva (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .awvalid(awvalid),
	.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
	.bvalid(bvalid), .bready(bready), .bresp(bresp), .arready(arready), .arvalid(arvalid), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .busy(busy), .flagsOut(flagsOut));
`default_nettype wire

/* verification/bwa_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bwa_host_model (
	input  wire logic        ref_clk,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [7:0]       awaddr,
	output logic             wvalid,
	input  wire logic        wready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             bready,
	input  wire logic        bvalid,
	input  wire logic [1:0]  bresp,
	output logic             arvalid,
	input  wire logic        arready,
	output logic [7:0]       araddr,
	output logic             rready,
	input  wire logic        rvalid,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp
);
	// Cycles by which bready or rready is held back after a request is taken; zero keeps them high.
	int lateAnswer = 0;
	// Ready lines idle high, so back-to-back calls without hold-back never re-drive them in one step.
	initial begin
		{awvalid, wvalid, arvalid} = 3'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		{bready, rready} = 2'h3;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		if (lateAnswer != 0) begin
			bready <= 1'b0;
		end
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		do begin
			@(posedge ref_clk);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (!(aw && w));
		if (lateAnswer != 0) begin
			repeat (lateAnswer) @(posedge ref_clk);
			bready <= 1'b1;
		end
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		r = bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		arvalid <= 1'b1;
		araddr <= a;
		if (lateAnswer != 0) begin
			rready <= 1'b0;
		end
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		if (lateAnswer != 0) begin
			repeat (lateAnswer) @(posedge ref_clk);
			rready <= 1'b1;
		end
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask
endmodule
`default_nettype wire

/* verification/byte_word_arith_logic_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_word_arith_logic_unit_tb;
	import bwa_pkg::*;
	logic ref_clk, rst, clkEn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, busy;
	logic [7:0] awaddr, araddr, flagsOut;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	bwa_op_t lastOp;
	int mismatches = 0;
	int checked = 0;
	// Row: op, dest, src, imm, pair high, flags in, dest out, pair high out, flags out.
	localparam logic [71:0] ROWS [12] = '{72'h007F0133000080002C, 72'h01FF00330001000023,
		72'h0210013300000F0020, 72'h0380003300017F0028, 72'h040533050010000012,
		72'h050033010001FE0025, 72'h06FF33010020000120, 72'h070033018000FF7F18,
		72'h08F03C0F0029300021, 72'h09AA0F550000000002, 72'h0A80017E0000810004,
		72'h0B007F000004000002};
	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;
	bwa_alu i_dut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .busy(busy), .lastOp(lastOp), .flagsOut(flagsOut));
	bwa_host_model i_host (.ref_clk(ref_clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bready(bready), .bvalid(bvalid),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rready(rready), .rvalid(rvalid),
		.rdata(rdata), .rresp(rresp));
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		i_host.wr(a, {24'h000000, d}, 4'hF, r);
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] d;
		logic [1:0] r;
		i_host.rd(a, d, r);
		check(n, d & m, e);
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		test_done();
	end
	initial begin
		logic [71:0] row;
		logic [31:0] d;
		logic [1:0] r;
		rst = 1'b1;
		clkEn = 1'b1;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rchk("flags", 8'h14, 32'h00000000, 32'hFFFFFFFF);
		for (int i = 0; i < 12; i++) begin
			row = ROWS[i];
			wreg(8'h04, row[63:56]);
			wreg(8'h08, row[55:48]);
			wreg(8'h0C, row[47:40]);
			wreg(8'h10, row[39:32]);
			wreg(8'h14, row[31:24]);
			wreg(8'h00, row[71:64]);
			do @(posedge ref_clk); while (busy !== 1'b0);
			check("lastOp", {28'h0000000, lastOp}, {24'h000000, row[71:64]});
			rchk("dest", 8'h04, {24'h000000, row[23:16]}, 32'hFFFFFFFF);
			rchk("pairHi", 8'h10, {24'h000000, row[15:8]}, 32'hFFFFFFFF);
			rchk("flags", 8'h14, {24'h000000, row[7:0]}, 32'hFFFFFFFF);
			rchk("cycles", 8'h18, (row[71:65] == 7'h03) ? 32'h00000020 : 32'h00000010, 32'h000000F0);
		end
		i_host.lateAnswer = 3;
		i_host.rd(8'h1C, d, r);
		check("unmapped read", {r, d[29:0]}, 32'h80000000);
		i_host.wr(8'h1C, 32'h0000005A, 4'hF, r);
		check("unmapped write", {30'h00000000, r}, 32'h00000002);
		i_host.lateAnswer = 0;
		i_host.wr(8'h04, 32'h000000AA, 4'hE, r);
		rchk("masked write", 8'h04, 32'h00000000, 32'hFFFFFFFF);
		// Freeze a word op between its two steps; it must resume where it stopped.
		wreg(8'h04, 8'hFF);
		wreg(8'h10, 8'hFF);
		wreg(8'h0C, 8'h01);
		wreg(8'h14, 8'h00);
		wreg(8'h00, 8'h06);
		clkEn <= 1'b0;
		repeat (4) @(posedge ref_clk);
		clkEn <= 1'b1;
		check("frozen busy", {31'h00000000, busy}, 32'h00000001);
		check("frozen flags", {24'h000000, flagsOut}, 32'h00000000);
		do @(posedge ref_clk); while (busy !== 1'b0);
		rchk("wrap dest", 8'h04, 32'h00000000, 32'hFFFFFFFF);
		rchk("wrap pairHi", 8'h10, 32'h00000000, 32'hFFFFFFFF);
		rchk("wrap flags", 8'h14, 32'h00000003, 32'hFFFFFFFF);
		wreg(8'h00, 8'h0C);
		check("ignored code", {28'h0000000, lastOp}, 32'h00000006);
		test_done();
	end
endmodule
`default_nettype wire
